// [dms_pkg.sv]
// dms_pkg: constants for the dual modulus synthesizer divider
// assumes a single core clock domain; all control through the instrument bus ports
package dms_pkg;
    localparam int DMS_PRESCALE_P   = 32;
    localparam int DMS_NIB_W        = 4;
    localparam int DMS_ADDR_W       = 3;
    localparam int DMS_LATCH_BITS   = 32;
    localparam int DMS_N_W          = 16;
    localparam int DMS_A_W          = 8;
    localparam int DMS_R_W          = 8;
    localparam int DMS_REF_IN_KHZ   = 1000;
    localparam int DMS_REF_OUT_KHZ  = 200;
    localparam int DMS_REF_DIV      = DMS_REF_IN_KHZ / DMS_REF_OUT_KHZ;
    // register addresses for nibble loads
    localparam logic [2:0] DMS_ADR_N0 = 3'h0;
    localparam logic [2:0] DMS_ADR_N1 = 3'h1;
    localparam logic [2:0] DMS_ADR_N2 = 3'h2;
    localparam logic [2:0] DMS_ADR_N3 = 3'h3;
    localparam logic [2:0] DMS_ADR_A0 = 3'h4;
    localparam logic [2:0] DMS_ADR_A1 = 3'h5;
    localparam logic [2:0] DMS_ADR_R0 = 3'h6;
    localparam logic [2:0] DMS_ADR_R1 = 3'h7;
    localparam logic [15:0] DMS_N_RST = 16'h0040;
    localparam logic [7:0]  DMS_A_RST = 8'h00;
    localparam logic [7:0]  DMS_R_RST = 8'h05;
endpackage

// [dms_prescaler.sv]
// dms_prescaler: dual modulus divider of the oscillator input
// assumes i_osc_edge is a synchronised rising edge of the counted signal
`timescale 1ns/1ps
`default_nettype none
module dms_prescaler
    import dms_pkg::*;
#(
    parameter int P = DMS_PRESCALE_P
) (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // control
    input  wire logic i_osc_edge,
    input  wire logic i_high_mod,
    input  wire logic i_restart,
    // output
    output logic      o_pulse
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       pulse;
    } dms_ps_t;

    dms_ps_t ps_reg;
    dms_ps_t ps_next;

    always_comb begin
        logic [7:0] modulus;
        modulus = i_high_mod ? 8'(P) : 8'(P - 1);
        ps_next = ps_reg;
        ps_next.pulse = 1'b0;
        if (i_restart) begin
            ps_next.cnt = 8'h00;
        end else if (i_osc_edge) begin
            if (ps_reg.cnt >= modulus) begin
                ps_next.cnt = 8'h00;
                ps_next.pulse = 1'b1;
            end else begin
                ps_next.cnt = ps_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ps_reg <= '0;
        end else begin
            ps_reg <= ps_next;
        end
    end

    assign o_pulse = ps_reg.pulse;
endmodule
`default_nettype wire

// [dms_divider.sv]
// dms_divider: programming latches, swallow/main counters, ref divider, pfd
// assumes bus lines and oscillator/reference inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - prescaler divides P+1 high, P low
// - cycle starts loaded, prescaler at P+1 if A nonzero or after reset, else P
// - main and swallow decrement per prescaler pulse
// - swallow zero switches modulus to P
// - main at one or below reloads both, one output pulse
// - swallow accepts zero, A+P*N per cycle after a reload
// - prescaler moduli are 32 and 33
// - main, swallow and reference counters present
// - values loaded as addressed 4-bit nibbles
// - nibble from upper lines on enable rise
// - low three lines select destination latch
// - thirty two latch bits hold values
// - reference divided by five to 200 kHz
// - two complementary detector pulse outputs
// - bus bit three latched oscillator on/off
// - off latch lowers divider input sensitivity
module dms_divider
    import dms_pkg::*;
#(
    parameter int N_W = DMS_N_W,
    parameter int A_W = DMS_A_W,
    parameter int R_W = DMS_R_W
) (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // instrument bus
    input  wire logic [7:0] i_bus_data,
    input  wire logic       i_bus_enable,
    // analog side inputs
    input  wire logic       i_osc_in,
    input  wire logic       i_ref_in,
    // outputs
    output logic            o_modulus_high,
    output logic            o_div_pulse,
    output logic            o_cmp_ref,
    output logic            o_phase_ref,
    output logic            o_phase_vco,
    output logic            o_osc_off,
    output logic            o_low_sense
);
    typedef struct packed {
        logic [2:0]     bus_en_s;
        logic [7:0]     bus_d1;
        logic [7:0]     bus_d2;
        logic [1:0]     osc_s;
        logic           osc_d;
        logic [1:0]     ref_s;
        logic           ref_d;
        logic [15:0]    n_val;
        logic [7:0]     a_val;
        logic [7:0]     r_val;
        logic [N_W-1:0] n_cnt;
        logic [A_W-1:0] a_cnt;
        logic [R_W-1:0] r_cnt;
        logic           mod_high;
        logic           restart;
        logic           div_pulse;
        logic           cmp_ref;
        logic           up;
        logic           dn;
        logic           osc_off;
    } dms_st_t;

    dms_st_t st_reg;
    dms_st_t st_next;
    logic    ps_pulse;

    function automatic logic [3:0] dms_nib(input logic [7:0] d);
        dms_nib = d[7:4];
    endfunction

    dms_prescaler #(
        .P(DMS_PRESCALE_P)
    ) u_ps (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_osc_edge (st_reg.osc_s[1] & ~st_reg.osc_d & ~st_reg.osc_off),
        .i_high_mod (st_reg.mod_high),
        .i_restart  (st_reg.restart),
        .o_pulse    (ps_pulse)
    );

    always_comb begin
        logic ref_edge;
        logic [3:0] nib;
        logic [R_W-1:0] rdiv;
        st_next = st_reg;
        ref_edge = 1'b0;
        nib = 4'h0;
        rdiv = '0;
        // pin synchronisers
        st_next.bus_en_s = {st_reg.bus_en_s[1:0], i_bus_enable};
        st_next.bus_d1 = i_bus_data;
        st_next.bus_d2 = st_reg.bus_d1;
        st_next.osc_s = {st_reg.osc_s[0], i_osc_in};
        st_next.osc_d = st_reg.osc_s[1];
        st_next.ref_s = {st_reg.ref_s[0], i_ref_in};
        st_next.ref_d = st_reg.ref_s[1];
        st_next.restart = 1'b0;
        st_next.div_pulse = 1'b0;
        // nibble load on enable rise
        if (st_reg.bus_en_s[1] & ~st_reg.bus_en_s[2]) begin
            nib = dms_nib(st_reg.bus_d2);
            st_next.osc_off = st_reg.bus_d2[3];
            unique case (st_reg.bus_d2[2:0])
                DMS_ADR_N0: st_next.n_val[3:0]   = nib;
                DMS_ADR_N1: st_next.n_val[7:4]   = nib;
                DMS_ADR_N2: st_next.n_val[11:8]  = nib;
                DMS_ADR_N3: st_next.n_val[15:12] = nib;
                DMS_ADR_A0: st_next.a_val[3:0]   = nib;
                DMS_ADR_A1: st_next.a_val[7:4]   = nib;
                DMS_ADR_R0: st_next.r_val[3:0]   = nib;
                DMS_ADR_R1: st_next.r_val[7:4]   = nib;
                default:    st_next.n_val = st_reg.n_val;
            endcase
        end
        // swallow and main counting
        if (ps_pulse) begin
            if (st_reg.n_cnt <= N_W'(1)) begin
                st_next.n_cnt = st_reg.n_val[N_W-1:0];
                st_next.a_cnt = st_reg.a_val[A_W-1:0];
                st_next.mod_high = (st_reg.a_val != 8'h00);
                st_next.restart = 1'b1;
                st_next.div_pulse = 1'b1;
            end else begin
                st_next.n_cnt = st_reg.n_cnt - N_W'(1);
                if (st_reg.a_cnt != '0) begin
                    st_next.a_cnt = st_reg.a_cnt - A_W'(1);
                    if (st_reg.a_cnt == A_W'(1)) begin
                        st_next.mod_high = 1'b0;
                    end
                end
            end
        end
        // reference divider
        rdiv = (st_reg.r_val == 8'h00) ? R_W'(1) : st_reg.r_val[R_W-1:0];
        if (st_reg.ref_s[1] & ~st_reg.ref_d) begin
            if (st_reg.r_cnt + R_W'(1) >= rdiv) begin
                st_next.r_cnt = '0;
                ref_edge = 1'b1;
            end else begin
                st_next.r_cnt = st_reg.r_cnt + R_W'(1);
            end
        end
        st_next.cmp_ref = ref_edge;
        // phase/frequency detector, both flags show before clearing
        if (st_reg.up & st_reg.dn) begin
            st_next.up = ref_edge;
            st_next.dn = st_reg.div_pulse;
        end else begin
            st_next.up = st_reg.up | ref_edge;
            st_next.dn = st_reg.dn | st_reg.div_pulse;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '{
                n_val:    DMS_N_RST,
                a_val:    DMS_A_RST,
                r_val:    DMS_R_RST,
                n_cnt:    DMS_N_RST[N_W-1:0],
                a_cnt:    DMS_A_RST[A_W-1:0],
                r_cnt:    '0,
                mod_high: 1'b1,
                osc_off:  1'b1,
                default:  '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_modulus_high = st_reg.mod_high;
    assign o_div_pulse    = st_reg.div_pulse;
    assign o_cmp_ref      = st_reg.cmp_ref;
    assign o_phase_ref    = ~st_reg.up;
    assign o_phase_vco    = st_reg.dn;
    assign o_osc_off      = st_reg.osc_off;
    assign o_low_sense    = st_reg.osc_off;
endmodule
`default_nettype wire

// [dms_monitor.sv]
// dms_monitor: port checks on dms_divider
// assumes bound into dms_divider, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dms_monitor (
    // clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    // bus
    input wire logic [7:0] i_bus_data,
    input wire logic       i_bus_enable,
    // outputs
    input wire logic       o_modulus_high,
    input wire logic       o_div_pulse,
    input wire logic       o_cmp_ref,
    input wire logic       o_phase_ref,
    input wire logic       o_phase_vco,
    input wire logic       o_osc_off,
    input wire logic       o_low_sense
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_MOD_RELOAD: assert property ($rose(o_modulus_high) |-> o_div_pulse)
        else $error("modulus raised outside reload");
    AST_SENSE: assert property (o_low_sense == o_osc_off)
        else $error("sense flag not equal off latch");
    AST_QUIET: assert property (o_osc_off [*8] |=> !o_div_pulse)
        else $error("divider pulsed while off");
    AST_DIV_ONE: assert property (o_div_pulse |=> !o_div_pulse)
        else $error("divided pulse too long");
    AST_CMP_GAP: assert property (o_cmp_ref |=> !o_cmp_ref [*2])
        else $error("reference pulses too close");
    AST_UP: assert property ($rose(o_cmp_ref) |-> ##[0:2] !o_phase_ref)
        else $error("no up pulse after reference");
    AST_DN: assert property ($rose(o_div_pulse) |-> ##[0:2] o_phase_vco)
        else $error("no down pulse after divider");
    AST_OFF: assert property ($rose(i_bus_enable) && i_bus_data[3]
        |-> ##[3:6] o_osc_off) else $error("off bit not latched");
    AST_ON: assert property ($rose(i_bus_enable) && !i_bus_data[3]
        |-> ##[3:6] !o_osc_off) else $error("on bit not latched");
endmodule
bind dms_divider dms_monitor mon_u (.i_core_clk, .i_rst, .i_bus_data,
    .i_bus_enable, .o_modulus_high, .o_div_pulse, .o_cmp_ref, .o_phase_ref,
    .o_phase_vco,
    .o_osc_off, .o_low_sense);
`default_nettype wire

// [dms_host.sv]
// dms_host: controller model writing nibbles on the bus
// assumes put is called just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dms_host (
    // clock
    input  wire logic i_core_clk,
    // bus
    output logic [7:0] o_bus_data,
    output logic       o_bus_enable
);
    initial begin
        o_bus_data   = 8'h00;
        o_bus_enable = 1'b0;
    end
    task automatic put(input logic [2:0] a, input logic [3:0] d,
                       input logic off);
        o_bus_data <= {d, off, a};
        repeat (2) @(posedge i_core_clk);
        o_bus_enable <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_bus_enable <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        o_bus_data <= ~{d, off, a};
        @(posedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// [tb_dual_modulus_synth_divider.sv]
// tb: loads random dividers, checks divide and reference periods
// assumes dms_host drives the bus, dms_monitor is bound
`timescale 1ns/1ps
`default_nettype none
module tb_dual_modulus_synth_divider
    import dms_pkg::*;
;
    logic       i_core_clk = 1'b0;
    logic       i_rst      = 1'b1;
    logic [7:0] i_bus_data;
    logic       i_bus_enable;
    logic       i_osc_in   = 1'b0;
    logic       i_ref_in   = 1'b0;
    logic       o_div_pulse, o_cmp_ref, o_osc_off;
    logic [1:0] ph         = 2'h0;
    logic [3:0] nv, av;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    int         gap = 0, cg = 0, npl = 0, n0, seed;
    int         exp_q[$];
    always #20 i_core_clk = ~i_core_clk;
    dms_host host_u (.i_core_clk, .o_bus_data(i_bus_data),
        .o_bus_enable(i_bus_enable));
    dms_divider dut_u (.i_core_clk, .i_rst, .i_bus_data, .i_bus_enable,
        .i_osc_in, .i_ref_in, .o_modulus_high(), .o_div_pulse, .o_cmp_ref,
        .o_phase_ref(), .o_phase_vco(), .o_osc_off, .o_low_sense());
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // osc and reference rise every four cycles
    always @(posedge i_core_clk) begin
        ph       <= ph + 2'h1;
        i_osc_in <= ph[1];
        i_ref_in <= ~ph[1];
    end
    always @(negedge i_core_clk) begin
        gap <= gap + 1;
        if (cg != 0)
            cg <= cg + 1;
        if (o_div_pulse === 1'b1) begin
            gap <= 1;
            npl <= npl + 1;
            if (exp_q.size() > 0)
                check(gap, exp_q.pop_front());
        end
        if (o_cmp_ref === 1'b1) begin
            cg <= 1;
            if (cg != 0)
                check(cg, DMS_REF_DIV * 4);
        end
    end
    initial begin
        seed = $urandom(16);
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        for (int t = 0; t < 4; t++) begin
            nv = 4'(2 + $urandom % 3);
            av = (t == 0) ? 4'h0 : 4'(1 + $urandom % 2);
            for (int k = 0; k < 4; k++)
                host_u.put(DMS_ADR_N0 + 3'(k), k == 0 ? nv : 4'h0, 1'b0);
            host_u.put(DMS_ADR_A0, av, 1'b0);
            host_u.put(DMS_ADR_A1, 4'h0, 1'b0);
            repeat (2) @(posedge i_core_clk iff o_div_pulse);
            exp_q.push_back((av + DMS_PRESCALE_P * nv) * 4);
            @(posedge i_core_clk iff o_div_pulse);
        end
        host_u.put(DMS_ADR_R0, 4'h5, 1'b1);
        n0 = npl;
        repeat (600) @(posedge i_core_clk);
        check({31'h0, o_osc_off}, 32'h1);
        check(npl, n0);
        close_out();
    end
    initial begin
        repeat (40000) @(posedge i_core_clk);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
